// ==== hw/operating_mode_two.sv ====
// Second operating mode register with registered steering outputs.
// Assumes the serial decoder gives one-cycle write strobes with a register address,
// all on clk; the processing engine reads the decoded controls.
`timescale 1ns/1ps
// Notes on behaviour
// - Bit 6 clear: harmonic coefficient derived automatically.
// - Bit 5 clear: fundamental coefficient from line frequency.
// - Bit 4 set stops all fundamental results.
// - Bit 3 picks linearity correction formula.
// - Bits 2:1 pick wiring system coefficient.
// - Bit 0 clear: apparent power is Vrms times Current_rms_value.
// - Bit 0 set: apparent power is vector length.
module operating_mode_two
    import opmode_two_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [11:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic harm_coef_auto,
    output logic fund_coef_auto,
    output logic fund_enable,
    output logic lin_rms_plus_offset,
    output wiring_e wiring,
    output logic app_vector_length
);
    // Reset state of the controls other than wiring is decoded from the reset byte so the two cannot disagree.
    localparam logic harm_reset = ~operating_mode_two_reset[harmonic_coef_auto_disable_pos];
    localparam logic fund_reset = ~operating_mode_two_reset[fundamental_coef_auto_disable_pos];
    localparam logic fen_reset = ~operating_mode_two_reset[fundamental_calc_disable_pos];
    localparam logic lin_reset = operating_mode_two_reset[linearity_formula_select_pos];
    localparam logic app_reset = operating_mode_two_reset[apparent_power_method_pos];

    // Address compare shared by the write and read paths.
    logic addr_hit;
    logic write_hit;

    // Stored mode byte and the value it takes at the coming edge.
    logic [7:0] mode_reg;
    logic [7:0] mode_next;

    // Registered read port.
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    // Controls decoded from the byte about to be stored.
    logic harm_dec;
    logic fund_dec;
    logic fen_dec;
    logic lin_dec;
    logic app_dec;
    wiring_e wir_dec;

    // Registered controls and their next values.
    logic harm_reg;
    logic harm_next;
    logic fund_reg;
    logic fund_next;
    logic fen_reg;
    logic fen_next;
    logic lin_reg;
    logic lin_next;
    wiring_e wir_reg;
    wiring_e wir_next;
    logic app_reg;
    logic app_next;

    always_comb begin
        addr_hit = (reg_addr == operating_mode_two_offset);
        write_hit = reg_wr && addr_hit;
    end

    // Each bit is its own flip-flop; bits outside the write mask never leave their reset value.
    genvar bit_idx;
    generate
        for (bit_idx = 0; bit_idx < 8; bit_idx = bit_idx + 1) begin : g_mode_bit
            logic bit_reg;
            logic bit_next;

            always_comb begin
                bit_next = bit_reg;
                if (write_hit) begin
                    bit_next = reg_wdata[bit_idx] & operating_mode_two_write_mask[bit_idx];
                end
            end

            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    bit_reg <= operating_mode_two_reset[bit_idx];
                end else begin
                    bit_reg <= bit_next;
                end
            end

            assign mode_reg[bit_idx] = bit_reg;
            assign mode_next[bit_idx] = bit_next;
        end
    endgenerate

    // Reading through the next value lets a read in the write cycle show the new byte.
    always_comb begin
        rdata_next = 8'h00;
        if (addr_hit) begin
            rdata_next = mode_next;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    mode_decode u_decode (
        .mode_byte(mode_next),
        .harm_coef_auto(harm_dec),
        .fund_coef_auto(fund_dec),
        .fund_enable(fen_dec),
        .lin_rms_plus_offset(lin_dec),
        .wiring(wir_dec),
        .app_vector_length(app_dec)
    );

    // Controls only move on a write, so the engine never sees a half-updated setting.
    always_comb begin
        harm_next = harm_reg;
        if (write_hit) begin
            harm_next = harm_dec;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            harm_reg <= harm_reset;
        end else begin
            harm_reg <= harm_next;
        end
    end

    // When low, the engine must take its fundamental coefficient from the host instead.
    always_comb begin
        fund_next = fund_reg;
        if (write_hit) begin
            fund_next = fund_dec;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fund_reg <= fund_reset;
        end else begin
            fund_reg <= fund_next;
        end
    end

    // When low, the engine skips every fundamental result to free processing time.
    always_comb begin
        fen_next = fen_reg;
        if (write_hit) begin
            fen_next = fen_dec;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fen_reg <= fen_reset;
        end else begin
            fen_reg <= fen_next;
        end
    end

    always_comb begin
        lin_next = lin_reg;
        if (write_hit) begin
            lin_next = lin_dec;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lin_reg <= lin_reset;
        end else begin
            lin_reg <= lin_next;
        end
    end

    // Code 11 is passed on as its own value; the engine has to treat it as unsupported.
    always_comb begin
        wir_next = wir_reg;
        if (write_hit) begin
            wir_next = wir_dec;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wir_reg <= wiring_single_or_four_wire;
        end else begin
            wir_reg <= wir_next;
        end
    end

    always_comb begin
        app_next = app_reg;
        if (write_hit) begin
            app_next = app_dec;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            app_reg <= app_reset;
        end else begin
            app_reg <= app_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign harm_coef_auto = harm_reg;
    assign fund_coef_auto = fund_reg;
    assign fund_enable = fen_reg;
    assign lin_rms_plus_offset = lin_reg;
    assign wiring = wir_reg;
    assign app_vector_length = app_reg;
endmodule // operating_mode_two

// ==== hw/opmode_two_pkg.sv ====
// Package for the second operating mode configuration register.
// Assumes a byte-wide register port driven by the serial command decoder.
package opmode_two_pkg;

    localparam logic [11:0] operating_mode_two_offset = 12'h003;
    localparam logic [7:0] operating_mode_two_reset = 8'h00;
    localparam logic [7:0] operating_mode_two_write_mask = 8'h7f;

    localparam int harmonic_coef_auto_disable_pos = 6;
    localparam int fundamental_coef_auto_disable_pos = 5;
    localparam int fundamental_calc_disable_pos = 4;
    localparam int linearity_formula_select_pos = 3;
    localparam int wiring_system_select_lsb = 1;
    localparam int apparent_power_method_pos = 0;

    typedef enum logic [1:0] {
        wiring_single_or_four_wire,
        wiring_three_phase_three_wire,
        wiring_three_volt_three_amp,
        wiring_unused
    } wiring_e;

    localparam logic [1:0] wiring_code_1p3w_3p4w = 2'h0;
    localparam logic [1:0] wiring_code_3p3w = 2'h1;
    localparam logic [1:0] wiring_code_3v3a = 2'h2;

endpackage

// ==== hw/mode_decode.sv ====
// Decodes the mode byte about to be stored into steering controls for the processing engine.
// Assumes the byte is the register's next value, formed on the same clock.
`timescale 1ns/1ps
module mode_decode
    import opmode_two_pkg::*;
(
    input wire logic [7:0] mode_byte,
    output logic harm_coef_auto,
    output logic fund_coef_auto,
    output logic fund_enable,
    output logic lin_rms_plus_offset,
    output wiring_e wiring,
    output logic app_vector_length
);
    always_comb begin
        harm_coef_auto = ~mode_byte[harmonic_coef_auto_disable_pos];
        fund_coef_auto = ~mode_byte[fundamental_coef_auto_disable_pos];
        fund_enable = ~mode_byte[fundamental_calc_disable_pos];
        lin_rms_plus_offset = mode_byte[linearity_formula_select_pos];
        app_vector_length = mode_byte[apparent_power_method_pos];
        case (mode_byte[wiring_system_select_lsb +: 2])
            wiring_code_1p3w_3p4w: wiring = wiring_single_or_four_wire;
            wiring_code_3p3w: wiring = wiring_three_phase_three_wire;
            wiring_code_3v3a: wiring = wiring_three_volt_three_amp;
            default: wiring = wiring_unused;
        endcase
    end
endmodule // mode_decode

// ==== sim/operating_mode_two_properties.sv ====
// Checker for the mode register ports.
// Assumes the bind below reaches every design instance.
`timescale 1ns/1ps
module operating_mode_two_properties
    import opmode_two_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [11:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic harm_coef_auto,
    input wire logic fund_coef_auto,
    input wire logic fund_enable,
    input wire logic lin_rms_plus_offset,
    input wire wiring_e wiring,
    input wire logic app_vector_length
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence w;
        reg_wr && reg_addr == operating_mode_two_offset;
    endsequence
    sequence w_then_read;
        w ##1 (reg_addr == operating_mode_two_offset && !reg_wr);
    endsequence
    sequence reset_state;
        reg_rdata == 8'h00 && harm_coef_auto && fund_coef_auto && fund_enable
            && !lin_rms_plus_offset && wiring == wiring_single_or_four_wire
            && !app_vector_length;
    endsequence
    AST_B6: assert property (w |=> harm_coef_auto != $past(reg_wdata[6]))
        else $error("b6");
    AST_B5: assert property (w |=> fund_coef_auto != $past(reg_wdata[5]))
        else $error("b5");
    AST_B4: assert property (w |=> fund_enable != $past(reg_wdata[4]))
        else $error("b4");
    AST_B3: assert property (w |=> lin_rms_plus_offset == $past(reg_wdata[3]))
        else $error("b3");
    AST_WIRE: assert property (w |=> wiring == $past(reg_wdata[2:1]))
        else $error("wiring");
    AST_SCALAR: assert property ((w and !reg_wdata[0]) |=> !app_vector_length)
        else $error("b0 clear");
    AST_VECTOR: assert property ((w and reg_wdata[0]) |=> app_vector_length)
        else $error("b0 set");
    AST_RSV: assert property (w_then_read |=>
        reg_rdata == (operating_mode_two_write_mask & $past(reg_wdata, 2)))
        else $error("readback");
    AST_RESET_VALUES: assert property ($fell(sys_rst) |-> reset_state)
        else $error("outputs not at reset state after reset release");
    AST_BIT7_ZERO: assert property (!reg_rdata[7])
        else $error("reserved bit read back as one");
endmodule // operating_mode_two_properties
bind operating_mode_two operating_mode_two_properties u_chk (.*);

// ==== sim/host_model.sv ====
// Host model issuing register writes; assumes calls start at a falling edge.
`timescale 1ns/1ps
module host_model (
    input wire logic clk,
    output logic [11:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata
);
    initial {reg_addr, reg_wr, reg_wdata} = '0;
    // Address stays put so the read back follows; data is scrambled once released.
    // The host sets the fundamental-disable bit only at a lowered rate with fundamentals
    // unneeded, or to shed load after an overrun; sent is the byte actually driven.
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input bit low_rate,
            input bit overrun, output logic [7:0] sent);
        sent = d;
        sent[opmode_two_pkg::fundamental_calc_disable_pos] = low_rate;
        if (overrun) sent[opmode_two_pkg::fundamental_calc_disable_pos] = 1'b1;
        {reg_addr, reg_wr, reg_wdata} = {a, 1'b1, sent};
        @(negedge clk) {reg_wr, reg_wdata} = {1'b0, ~sent};
    endtask
endmodule // host_model

// ==== sim/operating_mode_two_tb_top.sv ====
// Bench: random host writes checked against a byte model.
// Assumes the host model drives the register port and the checker is bound to the design.
`timescale 1ns/1ps
module operating_mode_two_tb_top import opmode_two_pkg::*;;
    logic clk = 1'b0, sys_rst = 1'b1;
    wire logic [11:0] reg_addr;
    wire logic reg_wr;
    wire logic [7:0] reg_wdata, reg_rdata;
    wire logic harm_coef_auto, fund_coef_auto, fund_enable, lin_rms_plus_offset, app_vector_length;
    wiring_e wiring;
    localparam int cycle_limit = 1000;
    int model_byte = 0, fails = 0, tests_run = 0, cyc = 0;
    int write_q[$];
    logic [11:0] a = 12'h000;
    logic [7:0] sent;
    logic [14:0] e;
    operating_mode_two u_dut (.*);
    host_model u_host (.*);
    always #20 clk = ~clk;
    wire logic [14:0] o = {reg_rdata, harm_coef_auto, fund_coef_auto, fund_enable,
        lin_rms_plus_offset, wiring, app_vector_length};
    // Expected outputs follow the meaning of each bit, never the design's own decode.
    function automatic logic [14:0] expect_out(input int mb, input logic [11:0] addr);
        logic [7:0] rd;
        rd = (addr == operating_mode_two_offset) ? 8'(mb) : 8'h00;
        return {rd, ~mb[harmonic_coef_auto_disable_pos], ~mb[fundamental_coef_auto_disable_pos],
            ~mb[fundamental_calc_disable_pos], mb[linearity_formula_select_pos],
            mb[wiring_system_select_lsb +: 2], mb[apparent_power_method_pos]};
    endfunction
    task automatic chk(input string name, input logic [14:0] seen, input logic [14:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk) if (++cyc > cycle_limit) begin
        fails++;
        report_and_stop();
    end
    initial begin
        void'($urandom(78));
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        for (int i = 0; i < 300; i++) begin
            if (i == 150) begin
                // A reset in mid-run must bring the mode byte back to zero and every output to the decode of that zero byte.
                sys_rst = 1'b1;
                write_q.delete();
                model_byte = 0;
                @(negedge clk);
                chk("reset outputs", o, expect_out(0, a));
                sys_rst = 1'b0;
            end
            while (write_q.size() > 0) model_byte = write_q.pop_front();
            e = expect_out(model_byte, a);
            chk("read data", 15'(reg_rdata), 15'(e[14:7]));
            chk("coef controls", 15'(o[6:4]), 15'(e[6:4]));
            chk("formula controls", 15'(o[3:0]), 15'(e[3:0]));
            a = $urandom_range(1) ? operating_mode_two_offset : 12'($urandom_range(4095));
            u_host.wr(a, 8'($urandom), 1'($urandom_range(1)), $urandom_range(3) == 0, sent);
            if (a == operating_mode_two_offset) begin
                write_q.push_back(int'(sent & operating_mode_two_write_mask));
            end
            @(negedge clk);
        end
        report_and_stop();
    end
endmodule // operating_mode_two_tb_top
